// file: hw/mpg_pkg.sv
// Constants and types for the page 14 access guard.
// Assumes one clock domain; the I2C slave, NVM loader and rheostat
// logic sit outside and talk to the guard on the same clock.
//
// Operation
// - Each space holds sixteen pages of sixteen bytes
// - NVM and EEPROM write or erase whole pages
// - Guards live in page 14 at E0, E1, E2
// - Block 000 guard access acts live, lost on reset
// - NVM page 14 applies only after reset reload
// - Register guard bits 1:0 set register read protection
// - Register guard bits 3:2 set register write protection
// - Register guard bit 4 gates matrix program signal
// - Register guard can block rheostat store to pages 12-13
// - NVM guard bits 1:0 block NVM read or write
// - EEPROM guard bit 2 enables EEPROM write protection
// - EEPROM guard bits 1:0 choose protected upper region
// - Lock bit at E4 freezes all three guards
// - Lock bit rejects writes to all of NVM page 14
// - Soft reset withheld while register writes fully protected
// - Lock plus NVM write block makes settings permanent
// - Block address 000 reg, 010 NVM, 011 EEPROM
// - Service pages 8 and 15 of reg and NVM readable, never written
package mpg_pkg;

   // Space geometry
   localparam int PAGE_COUNT = 16;
   localparam int PAGE_BYTES = 16;

   // Block addresses
   localparam logic [2:0] BLK_REG = 3'h0;
   localparam logic [2:0] BLK_NVM = 3'h2;
   localparam logic [2:0] BLK_EEP = 3'h3;

   // Guard byte word addresses
   localparam logic [7:0] ADDR_REG_GUARD = 8'hE0;
   localparam logic [7:0] ADDR_NVM_GUARD = 8'hE1;
   localparam logic [7:0] ADDR_EEP_GUARD = 8'hE2;
   localparam logic [7:0] ADDR_LOCK = 8'hE4;

   // Guard slots in the live copy
   localparam logic [1:0] SLOT_REG = 2'h0;
   localparam logic [1:0] SLOT_NVM = 2'h1;
   localparam logic [1:0] SLOT_EEP = 2'h2;
   localparam logic [1:0] SLOT_LOCK = 2'h3;

   // Special pages
   localparam logic [3:0] PAGE_GUARD = 4'hE;
   localparam logic [3:0] PAGE_SVC_LO = 4'h8;
   localparam logic [3:0] PAGE_SVC_HI = 4'hF;
   localparam logic [3:0] PAGE_RHEO_LO = 4'hC;
   localparam logic [3:0] PAGE_RHEO_HI = 4'hD;
   localparam logic [3:0] PAGE_OFFSET_ZERO = 4'h0;

   // Field positions
   localparam int RG_READ_LSB = 0;
   localparam int RG_WRITE_LSB = 2;
   localparam int RG_MATRIX_BIT = 4;
   localparam int NV_READ_BIT = 0;
   localparam int NV_WRITE_BIT = 1;
   localparam int EE_REGION_LSB = 0;
   localparam int EE_ENABLE_BIT = 2;
   localparam int LOCK_BIT = 0;

   // Implemented bits per guard; the rest read zero
   localparam logic [7:0] MASK_REG = 8'h1F;
   localparam logic [7:0] MASK_NVM = 8'h03;
   localparam logic [7:0] MASK_EEP = 8'h07;
   localparam logic [7:0] MASK_LOCK = 8'h01;
   localparam logic [7:0] GUARD_RESET = 8'h00;
   localparam logic [7:0] DATA_ZERO = 8'h00;

   // Register read/write protection codes
   localparam logic [1:0] PROT_NONE = 2'h0;
   localparam logic [1:0] PROT_PART = 2'h1;
   localparam logic [1:0] PROT_FULL = 2'h2;

   // EEPROM region codes and first protected page of each
   localparam logic [1:0] REGION_QUARTER = 2'h0;
   localparam logic [1:0] REGION_HALF = 2'h1;
   localparam logic [1:0] REGION_3QUARTER = 2'h2;
   localparam logic [3:0] FIRST_QUARTER = 4'hC;
   localparam logic [3:0] FIRST_HALF = 4'h8;
   localparam logic [3:0] FIRST_3QUARTER = 4'h4;
   localparam logic [3:0] FIRST_ALL = 4'h0;

   // Partial register protection starts here by default
   localparam logic [3:0] PART_FIRST_DEFAULT = 4'h8;

   // Access kinds
   typedef enum logic [1:0] {
      KIND_READ = 2'h0,
      KIND_WRITE = 2'h1,
      KIND_ERASE = 2'h2
   } mpg_kind_type;

   typedef enum {ST_LOAD, ST_READY} mpg_state_type;

endpackage

// file: hw/mpg_space_decode.sv
// Block address decoder for the three I2C spaces.
// Assumes a three bit block address from the I2C slave.
`timescale 1ns/10ps
module mpg_space_decode
   import mpg_pkg::*;
(
   // Address
   input wire logic [2:0] block,
   // Space selects
   output logic is_reg,
   output logic is_nvm,
   output logic is_eep
);

   // 001 and 1xx select nothing
   assign is_reg = (block == BLK_REG);
   assign is_nvm = (block == BLK_NVM);
   assign is_eep = (block == BLK_EEP);

endmodule

// file: hw/mpg_region_check.sv
// EEPROM software write protection region check.
// Assumes the page index of a write or erase request.
`timescale 1ns/10ps
module mpg_region_check
   import mpg_pkg::*;
(
   // Guard fields
   input wire logic enable,
   input wire logic [1:0] region,
   // Request page
   input wire logic [3:0] page,
   // Verdict
   output logic protect
);

   logic [3:0] first_page;

   // Regions always grow down from the top page
   assign first_page = (region == REGION_QUARTER) ? FIRST_QUARTER :
                       (region == REGION_HALF) ? FIRST_HALF :
                       (region == REGION_3QUARTER) ? FIRST_3QUARTER :
                       FIRST_ALL;

   // Disabled guard leaves the EEPROM open
   assign protect = enable && (page >= first_page);

endmodule

// file: hw/mpg_guard.sv
// Page 14 access guard: live copy of the protection bytes and the
// grant or refusal of every I2C read, write and erase.
// Assumes an I2C slave on the same clock that presents one request
// at a time and performs granted accesses itself, and an NVM loader
// that replays page 14 after every reset before raising LOAD_DONE.
`timescale 1ns/10ps
module mpg_guard
   import mpg_pkg::*;
#(
   parameter logic [3:0] PART_FIRST_PAGE = PART_FIRST_DEFAULT
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // NVM reload of page 14
   input wire logic LOAD_VALID,
   input wire logic [7:0] LOAD_WORD,
   input wire logic [7:0] LOAD_DATA,
   input wire logic LOAD_DONE,
   // Access request from the I2C slave
   input wire logic REQ_VALID,
   input wire logic [1:0] REQ_KIND,
   input wire logic [2:0] REQ_BLOCK,
   input wire logic [7:0] REQ_WORD,
   input wire logic [7:0] REQ_WDATA,
   output logic REQ_READY,
   // Access verdict
   output logic ACC_DONE,
   output logic ACC_GRANT,
   output logic [7:0] ACC_RDATA,
   // Connection matrix program signal
   input wire logic MATRIX_PROG_IN,
   output logic MATRIX_PROG_OUT,
   // Rheostat store into NVM pages 12 and 13
   input wire logic RHEO_STORE_REQ,
   output logic RHEO_STORE_GO,
   // Soft reset request
   input wire logic SOFT_RST_REQ,
   output logic SOFT_RST_GO
);

   // Slot of a guard byte, and whether the word is one
   function automatic logic [2:0] guard_slot(input logic [7:0] word);
      logic [2:0] res;
      res = 3'h0;
      case (word)
         ADDR_REG_GUARD: res = {1'b1, SLOT_REG};
         ADDR_NVM_GUARD: res = {1'b1, SLOT_NVM};
         ADDR_EEP_GUARD: res = {1'b1, SLOT_EEP};
         ADDR_LOCK: res = {1'b1, SLOT_LOCK};
         default: res = 3'h0;
      endcase
      return res;
   endfunction

   // Protection code applied to one page; 11 counts as full
   function automatic logic prot_active(input logic [1:0] code,
                                        input logic [3:0] page);
      logic res;
      res = 1'b1;
      case (code)
         PROT_NONE: res = 1'b0;
         PROT_PART: res = (page >= PART_FIRST_PAGE);
         default: res = 1'b1;
      endcase
      return res;
   endfunction

   // Mask of implemented bits for a slot
   function automatic logic [7:0] slot_mask(input logic [1:0] slot);
      logic [7:0] res;
      res = MASK_LOCK;
      case (slot)
         SLOT_REG: res = MASK_REG;
         SLOT_NVM: res = MASK_NVM;
         SLOT_EEP: res = MASK_EEP;
         default: res = MASK_LOCK;
      endcase
      return res;
   endfunction

   mpg_state_type state;
   mpg_state_type next_state;
   logic [7:0] guard [0:3];

   logic is_reg;
   logic is_nvm;
   logic is_eep;
   logic eep_protect;
   logic [3:0] page;
   logic aligned;
   logic svc_page;
   logic [2:0] req_slot;
   logic [2:0] load_slot;
   logic req_is_guard;
   logic locked;
   logic [1:0] reg_read_code;
   logic [1:0] reg_write_code;
   logic reg_write_full;
   logic nvm_read_block;
   logic nvm_write_block;
   logic reg_read_ok;
   logic reg_write_ok;
   logic nvm_read_ok;
   logic nvm_write_ok;
   logic eep_write_ok;
   logic read_ok;
   logic write_ok;
   logic erase_ok;
   logic grant;
   logic accept;
   logic guard_write;
   logic [7:0] next_rdata;

   mpg_space_decode u_space_decode (
      .block (REQ_BLOCK),
      .is_reg (is_reg),
      .is_nvm (is_nvm),
      .is_eep (is_eep)
   );

   // Sixteen pages of sixteen bytes: high nibble pages
   assign page = REQ_WORD[7:4];
   assign aligned = (REQ_WORD[3:0] == PAGE_OFFSET_ZERO);
   assign svc_page = (page == PAGE_SVC_LO) || (page == PAGE_SVC_HI);

   assign req_slot = guard_slot(REQ_WORD);
   assign load_slot = guard_slot(LOAD_WORD);
   assign req_is_guard = req_slot[2];

   // Guard fields from the live copy only
   assign locked = guard[SLOT_LOCK][LOCK_BIT];
   assign reg_read_code = guard[SLOT_REG][RG_READ_LSB +: 2];
   assign reg_write_code = guard[SLOT_REG][RG_WRITE_LSB +: 2];
   assign reg_write_full = (reg_write_code != PROT_NONE) &&
                           (reg_write_code != PROT_PART);
   assign nvm_read_block = guard[SLOT_NVM][NV_READ_BIT];
   assign nvm_write_block = guard[SLOT_NVM][NV_WRITE_BIT];

   mpg_region_check u_region_check (
      .enable (guard[SLOT_EEP][EE_ENABLE_BIT]),
      .region (guard[SLOT_EEP][EE_REGION_LSB +: 2]),
      .page (page),
      .protect (eep_protect)
   );

   // Guard bytes always read back their live value
   assign reg_read_ok = is_reg &&
      (req_is_guard || !prot_active(reg_read_code, page));

   // Locked guards refuse change even if writes are open
   assign reg_write_ok = is_reg && !svc_page &&
      !prot_active(reg_write_code, page) &&
      !(req_is_guard && locked);

   assign nvm_read_ok = is_nvm && !nvm_read_block;

   // Whole page only, service pages never, page 14 frozen by lock
   assign nvm_write_ok = is_nvm && aligned &&
      !nvm_write_block &&
      !svc_page &&
      !(locked && (page == PAGE_GUARD));

   assign eep_write_ok = is_eep && aligned && !eep_protect;

   // EEPROM reads are never guarded
   assign read_ok = reg_read_ok || nvm_read_ok || is_eep;
   assign write_ok = reg_write_ok || nvm_write_ok || eep_write_ok;
   // Erase exists only for the two page-erasable spaces
   assign erase_ok = nvm_write_ok || eep_write_ok;

   assign grant = (REQ_KIND == KIND_READ) ? read_ok :
                  (REQ_KIND == KIND_WRITE) ? write_ok :
                  (REQ_KIND == KIND_ERASE) ? erase_ok : 1'b0;

   // Requests wait until the reload has finished
   assign REQ_READY = (state == ST_READY);
   assign accept = REQ_VALID && REQ_READY;
   assign guard_write = accept && grant && is_reg && req_is_guard &&
                        (REQ_KIND == KIND_WRITE);

   assign next_rdata = (accept && grant && is_reg && req_is_guard &&
                        (REQ_KIND == KIND_READ)) ?
                       guard[req_slot[1:0]] : DATA_ZERO;

   always_comb begin
      next_state = state;
      case (state)
         ST_LOAD: begin
            if (LOAD_DONE) begin
               next_state = ST_READY;
            end
         end
         ST_READY: next_state = ST_READY;
         default: next_state = ST_LOAD;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state <= ST_LOAD;
      end else begin
         state <= next_state;
      end
   end

   // Reset discards live edits; the reload restores page 14
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_guard
         always_ff @(posedge CLK) begin
            if (SYS_RST) begin
               guard[gi] <= GUARD_RESET;
            end else if ((state == ST_LOAD) && LOAD_VALID && load_slot[2] &&
                         (load_slot[1:0] == 2'(gi))) begin
               guard[gi] <= LOAD_DATA & slot_mask(2'(gi));
            end else if (guard_write && (req_slot[1:0] == 2'(gi))) begin
               guard[gi] <= REQ_WDATA & slot_mask(2'(gi));
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ACC_DONE <= 1'b0;
         ACC_GRANT <= 1'b0;
         ACC_RDATA <= DATA_ZERO;
      end else begin
         ACC_DONE <= accept;
         ACC_GRANT <= accept && grant;
         ACC_RDATA <= next_rdata;
      end
   end

   // Side signals stay low until the guards are known
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         MATRIX_PROG_OUT <= 1'b0;
         RHEO_STORE_GO <= 1'b0;
         SOFT_RST_GO <= 1'b0;
      end else begin
         MATRIX_PROG_OUT <= REQ_READY && MATRIX_PROG_IN &&
            !guard[SLOT_REG][RG_MATRIX_BIT];
         // Pages 12 and 13 also obey the NVM write block
         RHEO_STORE_GO <= REQ_READY && RHEO_STORE_REQ &&
            !reg_write_full && !nvm_write_block;
         // Soft reset is how page 14 edits get reloaded
         SOFT_RST_GO <= REQ_READY && SOFT_RST_REQ && !reg_write_full;
      end
   end

endmodule

// file: dv/mpg_guard_props.sv
// Port checks for the page 14 access guard.
// Assumes a bind onto every mpg_guard instance.
`timescale 1ns/10ps
module mpg_guard_props
   import mpg_pkg::*;
#(
   parameter logic [3:0] PART_FIRST_PAGE = PART_FIRST_DEFAULT
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic LOAD_DONE,
   // Access bus
   input wire logic REQ_VALID,
   input wire logic [1:0] REQ_KIND,
   input wire logic [2:0] REQ_BLOCK,
   input wire logic [7:0] REQ_WORD,
   input wire logic REQ_READY,
   input wire logic ACC_DONE,
   input wire logic ACC_GRANT,
   input wire logic [7:0] ACC_RDATA,
   // Side strobes
   input wire logic MATRIX_PROG_IN,
   input wire logic MATRIX_PROG_OUT,
   input wire logic RHEO_STORE_REQ,
   input wire logic RHEO_STORE_GO,
   input wire logic SOFT_RST_REQ,
   input wire logic SOFT_RST_GO
);
   wire take = REQ_VALID && REQ_READY;
   wire svc = REQ_WORD[7:4] == 4'h8 || REQ_WORD[7:4] == 4'hF;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   property p_svc;
      take && REQ_KIND != 2'h0 && !REQ_BLOCK[0] && !REQ_BLOCK[2] && svc
      |=> ACC_DONE && !ACC_GRANT;
   endproperty
   a_svc: assert property (p_svc) else $error("service page written");
   property p_blk;
      take && (REQ_BLOCK == 3'h1 || REQ_BLOCK[2]) |=> ACC_DONE && !ACC_GRANT;
   endproperty
   a_blk: assert property (p_blk) else $error("empty block granted");
   property p_align;
      take && REQ_KIND != 2'h0 && REQ_BLOCK[2:1] == 2'h1
      && REQ_WORD[3:0] != 4'h0 |=> ACC_DONE && !ACC_GRANT;
   endproperty
   a_align: assert property (p_align) else $error("part page granted");
   property p_eep;
      take && REQ_KIND == 2'h0 && REQ_BLOCK == 3'h3 |=> ACC_DONE && ACC_GRANT;
   endproperty
   a_eep: assert property (p_eep) else $error("EEPROM read refused");
   property p_rdata;
      ACC_RDATA != 8'h00 |-> ACC_GRANT && $past(REQ_BLOCK == 3'h0);
   endproperty
   a_rdata: assert property (p_rdata) else $error("stray read data");
   property p_ready;
      $rose(REQ_READY) |-> $past(LOAD_DONE);
   endproperty
   a_ready: assert property (p_ready) else $error("ready before load");
   property p_prog;
      MATRIX_PROG_OUT |-> $past(MATRIX_PROG_IN) && $past(REQ_READY);
   endproperty
   a_prog: assert property (p_prog) else $error("stray program");
   property p_rheo;
      RHEO_STORE_GO |-> $past(RHEO_STORE_REQ);
   endproperty
   a_rheo: assert property (p_rheo) else $error("stray store");
   property p_soft;
      SOFT_RST_GO |-> $past(SOFT_RST_REQ) && $past(REQ_READY);
   endproperty
   a_soft: assert property (p_soft) else $error("stray soft reset");
endmodule

bind mpg_guard mpg_guard_props #(.PART_FIRST_PAGE(PART_FIRST_PAGE)) u_props (
   .CLK(CLK), .SYS_RST(SYS_RST), .LOAD_DONE(LOAD_DONE),
   .REQ_VALID(REQ_VALID), .REQ_KIND(REQ_KIND), .REQ_BLOCK(REQ_BLOCK),
   .REQ_WORD(REQ_WORD), .REQ_READY(REQ_READY), .ACC_DONE(ACC_DONE),
   .ACC_GRANT(ACC_GRANT), .ACC_RDATA(ACC_RDATA),
   .MATRIX_PROG_IN(MATRIX_PROG_IN), .MATRIX_PROG_OUT(MATRIX_PROG_OUT),
   .RHEO_STORE_REQ(RHEO_STORE_REQ), .RHEO_STORE_GO(RHEO_STORE_GO),
   .SOFT_RST_REQ(SOFT_RST_REQ), .SOFT_RST_GO(SOFT_RST_GO)
);

// file: dv/mpg_loader_model.sv
// Model of the NVM loader that replays page 14 after each reset.
// Assumes the bench sets the image before reset is released.
`timescale 1ns/10ps
module mpg_loader_model
   import mpg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Stored image: lock, EEPROM, NVM, register guard
   input wire logic [31:0] image,
   // Reload strobes
   output logic load_valid,
   output logic [7:0] load_word,
   output logic [7:0] load_data,
   output logic load_done
);
   logic run;
   logic [2:0] step;
   logic [31:0] shifted;
   // Fifth byte is a tolerance byte the guard must ignore
   assign shifted = image >> {step, 3'h0};
   assign load_valid = run && step < 3'h5;
   assign load_done = run && step == 3'h5;
   // Step 4 replays a tolerance byte, never a guard slot
   assign load_word = (step == 3'h3) ? ADDR_LOCK :
                      (step == 3'h4) ? 8'hE6 : 8'hE0 + {5'h0, step};
   // Idle data changes until the step saturates at 7, so a stale capture shows
   assign load_data = step < 3'h4 ? shifted[7:0] : {5'h0, step} ^ 8'hA5;
   always_ff @(posedge clk) begin
      run <= !rst;
      step <= (rst || !run) ? 3'h0 : step + {2'h0, step != 3'h7};
   end
endmodule

// file: dv/mpg_guard_tb_top.sv
// Self-checking bench for the page 14 access guard.
// Assumes the loader model stands in for the NVM reload path.
`timescale 1ns/10ps
module mpg_guard_tb_top
   import mpg_pkg::*;
;
   localparam logic [3:0] PART = 4'h6;
   localparam logic [7:0] LO = {PART - 4'h1, 4'h0};
   localparam logic [7:0] HI = {PART, 4'h0};
   logic clk = 1'b0;
   logic rst, req_valid, prog_in, rheo_req, soft_req;
   logic [1:0] kind;
   logic [2:0] blk;
   logic [7:0] word, wdata, rd;
   logic [31:0] image;
   wire lv, ldone, ready, done, grant, prog_out, rheo_go, soft_go;
   wire [7:0] lw, ldat, rdata;
   int error_cnt, checks;
   always #20 clk = ~clk;
   mpg_loader_model u_loader (.clk(clk), .rst(rst), .image(image),
      .load_valid(lv), .load_word(lw), .load_data(ldat), .load_done(ldone));
   // Partial span extended down to page 6 to reach both sides of it
   mpg_guard #(.PART_FIRST_PAGE(PART)) dut (.CLK(clk), .SYS_RST(rst),
      .LOAD_VALID(lv), .LOAD_WORD(lw), .LOAD_DATA(ldat), .LOAD_DONE(ldone),
      .REQ_VALID(req_valid), .REQ_KIND(kind), .REQ_BLOCK(blk),
      .REQ_WORD(word), .REQ_WDATA(wdata), .REQ_READY(ready),
      .ACC_DONE(done), .ACC_GRANT(grant), .ACC_RDATA(rdata),
      .MATRIX_PROG_IN(prog_in), .MATRIX_PROG_OUT(prog_out),
      .RHEO_STORE_REQ(rheo_req), .RHEO_STORE_GO(rheo_go),
      .SOFT_RST_REQ(soft_req), .SOFT_RST_GO(soft_go));
   task automatic give_verdict();
      if (error_cnt == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk_byte(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      chk_byte(nm, {7'h0, e}, {7'h0, g});
   endtask
   task automatic op(input logic [1:0] k, input logic [2:0] b,
      input logic [7:0] w, input logic [7:0] d, input logic eg);
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      kind <= k;
      blk <= b;
      word <= w;
      wdata <= d;
      @(posedge clk);
      req_valid <= 1'b0;
      word <= ~w;
      #1;
      for (n = 0; done !== 1'b1 && n < 4; n++) begin
         @(posedge clk);
         #1;
      end
      if (n == 4) begin
         error_cnt++;
         give_verdict();
      end
      chk_bit($sformatf("grant %h %h %h", k, b, w), eg, grant);
      rd = rdata;
   endtask
   task automatic do_reset();
      int n;
      @(posedge clk);
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (n = 0; ready !== 1'b1 && n < 50; n++) begin
         @(posedge clk);
         #1;
      end
      if (n == 50) begin
         error_cnt++;
         give_verdict();
      end
   endtask
   task automatic t_guards();
      logic [7:0] a [3] = '{ADDR_REG_GUARD, ADDR_NVM_GUARD, ADDR_EEP_GUARD};
      // Register write bits stay clear so the restore is not refused
      logic [7:0] d [3] = '{8'hF3, 8'hFF, 8'hFF};
      logic [7:0] m [3] = '{8'h13, MASK_NVM, MASK_EEP};
      for (int i = 0; i < 3; i++) begin
         op(2'h1, BLK_REG, a[i], d[i], 1'b1);
         op(2'h0, BLK_REG, a[i], 8'h00, 1'b1);
         chk_byte("guard", m[i], rd);
         op(2'h1, BLK_REG, a[i], 8'h00, 1'b1);
      end
   endtask
   task automatic t_regs();
      op(2'h1, BLK_REG, 8'h80, 8'h00, 1'b0);
      op(2'h1, BLK_REG, 8'hF0, 8'h00, 1'b0);
      for (int c = 0; c < 4; c++) begin
         // Write codes shut page 14 as well, so each code starts clean
         do_reset();
         op(2'h1, BLK_REG, ADDR_REG_GUARD, 8'(c * 5), 1'b1);
         op(2'h0, BLK_REG, LO, 8'h00, c < 2);
         op(2'h0, BLK_REG, HI, 8'h00, c == 0);
         op(2'h1, BLK_REG, LO, 8'h00, c < 2);
         op(2'h1, BLK_REG, HI, 8'h00, c == 0);
      end
      op(2'h0, BLK_REG, ADDR_REG_GUARD, 8'h00, 1'b1);
      chk_byte("reg guard", 8'h0F, rd);
      op(2'h1, BLK_REG, ADDR_REG_GUARD, 8'h00, 1'b0);
      do_reset();
   endtask
   task automatic t_nvm();
      for (int c = 0; c < 4; c++) begin
         op(2'h1, BLK_REG, ADDR_NVM_GUARD, 8'(c), 1'b1);
         op(2'h0, BLK_NVM, 8'h10, 8'h00, c % 2 == 0);
         op(2'h1, BLK_NVM, 8'h10, 8'h00, c < 2);
         op(2'h2, BLK_NVM, 8'h20, 8'h00, c < 2);
      end
      op(2'h1, BLK_REG, ADDR_NVM_GUARD, 8'h00, 1'b1);
      op(2'h1, BLK_NVM, 8'h11, 8'h00, 1'b0);
      op(2'h2, BLK_EEP, 8'h13, 8'h00, 1'b0);
      op(2'h1, BLK_NVM, 8'h80, 8'h00, 1'b0);
      op(2'h0, BLK_NVM, 8'hF0, 8'h00, 1'b1);
      op(2'h1, 3'h1, 8'h10, 8'h00, 1'b0);
      op(2'h0, 3'h5, 8'h10, 8'h00, 1'b0);
      op(2'h2, BLK_REG, 8'h10, 8'h00, 1'b0);
      op(2'h3, BLK_EEP, 8'h10, 8'h00, 1'b0);
   endtask
   task automatic t_eep();
      logic [3:0] f;
      op(2'h1, BLK_EEP, 8'hF0, 8'h00, 1'b1);
      for (int c = 0; c < 4; c++) begin
         op(2'h1, BLK_REG, ADDR_EEP_GUARD, 8'(4 + c), 1'b1);
         f = 4'hC - 4'(c * 4);
         op(2'h1, BLK_EEP, {f, 4'h0}, 8'h00, 1'b0);
         op(2'h2, BLK_EEP, 8'hF0, 8'h00, 1'b0);
         if (c < 3) op(2'h1, BLK_EEP, {f - 4'h1, 4'h0}, 8'h00, 1'b1);
         op(2'h0, BLK_EEP, 8'hF0, 8'h00, 1'b1);
      end
      op(2'h1, BLK_REG, ADDR_EEP_GUARD, 8'h03, 1'b1);
      op(2'h2, BLK_EEP, 8'h00, 8'h00, 1'b1);
   endtask
   task automatic t_side();
      logic [7:0] e0 [5] = '{8'h00, 8'h10, 8'h08, 8'h04, 8'h0C};
      logic [7:0] e1 [5] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
      logic [2:0] ex [5] = '{3'h7, 3'h3, 3'h4, 3'h6, 3'h4};
      logic [7:0] got;
      @(posedge clk);
      prog_in <= 1'b1;
      rheo_req <= 1'b1;
      soft_req <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         // Any write code shuts page 14, so each case starts clean
         do_reset();
         op(2'h1, BLK_REG, ADDR_NVM_GUARD, e1[i], 1'b1);
         op(2'h1, BLK_REG, ADDR_REG_GUARD, e0[i], 1'b1);
         @(posedge clk);
         #1;
         got = {5'h0, prog_out, soft_go, rheo_go};
         chk_byte("side", {5'h0, ex[i]}, got);
      end
      do_reset();
   endtask
   task automatic t_lock();
      op(2'h1, BLK_REG, ADDR_NVM_GUARD, 8'h00, 1'b1);
      op(2'h2, BLK_NVM, 8'hE0, 8'h00, 1'b1);
      op(2'h1, BLK_NVM, 8'hE0, 8'h00, 1'b1);
      op(2'h1, BLK_REG, ADDR_REG_GUARD, 8'h11, 1'b1);
      op(2'h1, BLK_REG, ADDR_LOCK, 8'h01, 1'b1);
      op(2'h1, BLK_REG, ADDR_LOCK, 8'h00, 1'b0);
      op(2'h1, BLK_REG, ADDR_REG_GUARD, 8'h00, 1'b0);
      op(2'h1, BLK_REG, ADDR_EEP_GUARD, 8'h07, 1'b0);
      op(2'h0, BLK_REG, ADDR_REG_GUARD, 8'h00, 1'b1);
      chk_byte("locked guard", 8'h11, rd);
      op(2'h1, BLK_NVM, 8'hE0, 8'h00, 1'b0);
      op(2'h2, BLK_NVM, 8'hE0, 8'h00, 1'b0);
      op(2'h1, BLK_NVM, 8'hD0, 8'h00, 1'b1);
   endtask
   task automatic t_reload();
      image <= 32'h01000200;
      do_reset();
      op(2'h0, BLK_REG, ADDR_LOCK, 8'h00, 1'b1);
      chk_byte("lock", 8'h01, rd);
      op(2'h0, BLK_REG, ADDR_REG_GUARD, 8'h00, 1'b1);
      chk_byte("reg guard", 8'h00, rd);
      op(2'h0, BLK_REG, ADDR_NVM_GUARD, 8'h00, 1'b1);
      chk_byte("nvm guard", 8'h02, rd);
      op(2'h1, BLK_REG, ADDR_NVM_GUARD, 8'h00, 1'b0);
      op(2'h2, BLK_NVM, 8'hE0, 8'h00, 1'b0);
   endtask
   initial begin
      {rst, req_valid, prog_in, rheo_req, soft_req} = 5'h10;
      {kind, blk, word, wdata} = 21'h0;
      image = 32'h0;
      error_cnt = 0;
      checks = 0;
      do_reset();
      t_guards();
      t_regs();
      t_nvm();
      t_eep();
      t_side();
      t_lock();
      t_reload();
      give_verdict();
   end
endmodule
